// ==== pkg/chb_pkg.sv ====
// constants, types and helpers shared by the charger register bank
package chb_pkg;

  // bus identity and map limits
  localparam logic [6:0] CHB_SLAVE_ADDR = 7'h6A;
  localparam logic [7:0] CHB_LAST_REG   = 8'h0C;
  localparam logic [7:0] CHB_READ_BEYOND = 8'hFF;
  localparam int         CHB_NUM_REGS   = 13;

  // register offsets
  localparam logic [3:0] CHB_OFS_INPUT_CURRENT_LIMIT = 4'h0;
  localparam logic [3:0] CHB_OFS_CHARGER_CONTROL_0   = 4'h1;
  localparam logic [3:0] CHB_OFS_CHARGE_CURRENT_LIMIT = 4'h2;
  localparam logic [3:0] CHB_OFS_PRECHARGE_TERM_LIMIT = 4'h3;
  localparam logic [3:0] CHB_OFS_BATTERY_VOLTAGE_LIMIT = 4'h4;
  localparam logic [3:0] CHB_OFS_CHARGER_CONTROL_1   = 4'h5;
  localparam logic [3:0] CHB_OFS_CHARGER_CONTROL_2   = 4'h6;
  localparam logic [3:0] CHB_OFS_CHARGER_CONTROL_3   = 4'h7;
  localparam logic [3:0] CHB_OFS_CHARGER_STATUS_0    = 4'h8;
  localparam logic [3:0] CHB_OFS_CHARGER_STATUS_1    = 4'h9;
  localparam logic [3:0] CHB_OFS_CHARGER_STATUS_2    = 4'hA;
  localparam logic [3:0] CHB_OFS_PART_INFORMATION    = 4'hB;
  localparam logic [3:0] CHB_OFS_CHARGER_CONTROL_4   = 4'hC;

  // input current limit register fields
  localparam int CHB_HIZ_BIT    = 7;
  localparam int CHB_BYPASS_BIT = 6;
  localparam int CHB_RSENSE_BIT = 5;
  localparam int CHB_ICL_MSB    = 4;
  localparam logic [4:0] CHB_ICL_CODE_500MA  = 5'h04;
  localparam logic [4:0] CHB_ICL_CODE_2400MA = 5'h17;

  // thermistor fault field inside charger status 1
  localparam int         CHB_NTC_LSB    = 0;
  localparam int         CHB_NTC_MSB    = 2;
  localparam logic [2:0] CHB_NTC_NORMAL = 3'h0;

  // reset values
  localparam logic [7:0] CHB_RST_R00 = 8'h17;
  localparam logic [7:0] CHB_RST_R01 = 8'h1A;
  localparam logic [7:0] CHB_RST_R02 = 8'h91;
  localparam logic [7:0] CHB_RST_R03 = 8'h12;
  localparam logic [7:0] CHB_RST_RXX = 8'h00;
  localparam logic       CHB_PIN_IDLE = 1'b1;

  typedef enum logic [3:0] {
    CHB_ST_IDLE      = 4'h0,
    CHB_ST_ADDR      = 4'h1,
    CHB_ST_ADDR_ACK  = 4'h2,
    CHB_ST_REG       = 4'h3,
    CHB_ST_REG_ACK   = 4'h4,
    CHB_ST_WDATA     = 4'h5,
    CHB_ST_WDATA_ACK = 4'h6,
    CHB_ST_RDATA     = 4'h7,
    CHB_ST_RDATA_ACK = 4'h8
  } chb_state_t;

  function automatic logic chb_is_ro(input logic [3:0] ofs);
    return (ofs >= CHB_OFS_CHARGER_STATUS_0) && (ofs <= CHB_OFS_PART_INFORMATION);
  endfunction

  function automatic logic [7:0] chb_rst_val(input logic [3:0] ofs);
    logic [7:0] v;
    v = CHB_RST_RXX;
    if (ofs == CHB_OFS_INPUT_CURRENT_LIMIT) v = CHB_RST_R00;
    if (ofs == CHB_OFS_CHARGER_CONTROL_0) v = CHB_RST_R01;
    if (ofs == CHB_OFS_CHARGE_CURRENT_LIMIT) v = CHB_RST_R02;
    if (ofs == CHB_OFS_PRECHARGE_TERM_LIMIT) v = CHB_RST_R03;
    return v;
  endfunction

endpackage

// ==== rtl/chb_sync.sv ====
// three-stage pin synchroniser with two-stage agreement filter
`timescale 1ns/1ns
module chb_sync
  import chb_pkg::*;
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s1_q <= CHB_PIN_IDLE;
      s2_q <= CHB_PIN_IDLE;
      s3_q <= CHB_PIN_IDLE;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // change counts only once the later two stages agree
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      level_out <= CHB_PIN_IDLE;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule

// ==== rtl/chb_regs.sv ====
// storage of the read/write registers and automatic field updates
`timescale 1ns/1ns
module chb_regs
  import chb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // device events
  input  wire logic        reg_reset_in,
  input  wire logic        watchdog_expired_in,
  input  wire logic        src_detect_done_in,
  input  wire logic        src_select_high_in,
  input  wire logic        sense_done_in,
  input  wire logic        sense_absent_in,
  // write port
  input  wire logic        wr_en_in,
  input  wire logic [3:0]  wr_addr_in,
  input  wire logic [7:0]  wr_data_in,
  // register contents
  output logic [7:0]       bank_out [CHB_NUM_REGS],
  output logic             sense_detect_start_out
);

  logic [7:0] bank_q [CHB_NUM_REGS];

  // later assignments win: device updates override a same-cycle host write
  always_ff @(posedge mclk_in) begin
    if (rst_in || reg_reset_in) begin
      for (int i = 0; i < CHB_NUM_REGS; i++) begin
        bank_q[i] <= chb_rst_val(4'(i));
      end
    end else begin
      if (wr_en_in && (wr_addr_in <= CHB_LAST_REG[3:0]) && !chb_is_ro(wr_addr_in)) begin
        bank_q[wr_addr_in] <= wr_data_in;
      end
      if (watchdog_expired_in) begin
        bank_q[CHB_OFS_INPUT_CURRENT_LIMIT][CHB_HIZ_BIT] <= 1'b0;
      end
      if (sense_done_in) begin
        bank_q[CHB_OFS_INPUT_CURRENT_LIMIT][CHB_RSENSE_BIT] <= sense_absent_in;
      end
      if (src_detect_done_in) begin
        bank_q[CHB_OFS_INPUT_CURRENT_LIMIT][CHB_ICL_MSB:0] <=
          src_select_high_in ? CHB_ICL_CODE_500MA : CHB_ICL_CODE_2400MA;
      end
    end
  end

  // host clearing the disable bit asks for a fresh detection
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sense_detect_start_out <= 1'b0;
    end else begin
      sense_detect_start_out <= wr_en_in && !reg_reset_in
        && (wr_addr_in == CHB_OFS_INPUT_CURRENT_LIMIT)
        && !wr_data_in[CHB_RSENSE_BIT];
    end
  end

  always_comb begin
    for (int i = 0; i < CHB_NUM_REGS; i++) begin
      bank_out[i] = bank_q[i];
    end
  end

endmodule

// ==== rtl/chb_top.sv ====
// serial-bus slave and register bank of the single-cell charger
`timescale 1ns/1ns
module chb_top
  import chb_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // source detection
  input  wire logic        src_select_in,
  input  wire logic        src_detect_done_in,
  // remote sense detection
  input  wire logic        sense_done_in,
  input  wire logic        sense_absent_in,
  output logic             sense_detect_start_out,
  // resets from the charger core
  input  wire logic        reg_reset_in,
  input  wire logic        watchdog_expired_in,
  // thermistor
  input  wire logic        thermistor_ok_in,
  input  wire logic [2:0]  thermistor_fault_field_in,
  output logic             charge_thermistor_good_out,
  // status sources
  input  wire logic [7:0]  status_0_in,
  input  wire logic [7:0]  status_1_in,
  input  wire logic [7:0]  status_2_in,
  input  wire logic [7:0]  part_info_in,
  // configuration towards the charger core
  output logic             high_impedance_enable_out,
  output logic             thermistor_bypass_out,
  output logic             remote_sense_disable_out,
  output logic             regulate_remote_sense_out,
  output logic [4:0]       input_current_limit_code_out,
  output logic [63:0]      control_bank_out,
  output logic             bus_busy_out
);

  logic             scl_f;
  logic             sda_f;
  logic             src_high_f;
  logic             scl_p_q;
  logic             sda_p_q;
  logic             rise;
  logic             fall;
  logic             start_c;
  logic             stop_c;
  chb_state_t       state_q;
  logic [2:0]       cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       byte_c;
  logic [7:0]       ptr_q;
  logic [7:0]       tx_q;
  logic [7:0]       rd_data_c;
  logic             rd_mode_q;
  logic             ack_q;
  logic             wr_en_q;
  logic [3:0]       wr_addr_q;
  logic [7:0]       wr_data_q;
  logic [7:0]       bank [CHB_NUM_REGS];
  logic [7:0]       input_current_limit;
  logic [7:0]       status_1_c;

  chb_sync u_sync_scl (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (scl_in),
    .level_out (scl_f)
  );

  chb_sync u_sync_sda (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (sda_in),
    .level_out (sda_f)
  );

  chb_sync u_sync_psel (
    .mclk_in   (mclk_in),
    .rst_in    (rst_in),
    .pin_in    (src_select_in),
    .level_out (src_high_f)
  );

  chb_regs u_regs (
    .mclk_in                (mclk_in),
    .rst_in                 (rst_in),
    .reg_reset_in           (reg_reset_in),
    .watchdog_expired_in    (watchdog_expired_in),
    .src_detect_done_in     (src_detect_done_in),
    .src_select_high_in     (src_high_f),
    .sense_done_in          (sense_done_in),
    .sense_absent_in        (sense_absent_in),
    .wr_en_in               (wr_en_q),
    .wr_addr_in             (wr_addr_q),
    .wr_data_in             (wr_data_q),
    .bank_out               (bank),
    .sense_detect_start_out (sense_detect_start_out)
  );

  assign input_current_limit = bank[CHB_OFS_INPUT_CURRENT_LIMIT];

  // bus line events from filtered levels
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      scl_p_q <= CHB_PIN_IDLE;
      sda_p_q <= CHB_PIN_IDLE;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  assign rise    = scl_f && !scl_p_q;
  assign fall    = !scl_f && scl_p_q;
  assign start_c = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop_c  = scl_f && scl_p_q && !sda_p_q && sda_f;
  assign byte_c  = {shift_q[6:0], sda_f};

  // fault field reads normal while the thermistor is bypassed
  always_comb begin
    status_1_c = status_1_in;
    status_1_c[CHB_NTC_MSB:CHB_NTC_LSB] =
      input_current_limit[CHB_BYPASS_BIT] ? CHB_NTC_NORMAL : thermistor_fault_field_in;
  end

  // read data for the current pointer
  always_comb begin
    rd_data_c = CHB_READ_BEYOND;
    if (ptr_q > CHB_LAST_REG) begin
      rd_data_c = CHB_READ_BEYOND;
    end else begin
      unique case (ptr_q[3:0])
        CHB_OFS_CHARGER_STATUS_0: rd_data_c = status_0_in;
        CHB_OFS_CHARGER_STATUS_1: rd_data_c = status_1_c;
        CHB_OFS_CHARGER_STATUS_2: rd_data_c = status_2_in;
        CHB_OFS_PART_INFORMATION: rd_data_c = part_info_in;
        default:                  rd_data_c = bank[ptr_q[3:0]];
      endcase
    end
  end

  // transfer sequencing, acted on at each clock-line rise
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q   <= CHB_ST_IDLE;
      cnt_q     <= 3'h0;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      tx_q      <= 8'h00;
      rd_mode_q <= 1'b0;
      ack_q     <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 4'h0;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (start_c) begin
        state_q <= CHB_ST_ADDR;
        cnt_q   <= 3'h0;
      end else if (stop_c) begin
        state_q <= CHB_ST_IDLE;
      end else if (rise) begin
        unique case (state_q)
          CHB_ST_IDLE: begin
          end
          CHB_ST_ADDR: begin
            shift_q <= byte_c;
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              ack_q     <= (byte_c[7:1] == CHB_SLAVE_ADDR);
              rd_mode_q <= byte_c[0];
              state_q   <= CHB_ST_ADDR_ACK;
            end
          end
          CHB_ST_REG: begin
            shift_q <= byte_c;
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              ptr_q   <= byte_c;
              ack_q   <= (byte_c <= CHB_LAST_REG);
              state_q <= CHB_ST_REG_ACK;
            end
          end
          CHB_ST_WDATA: begin
            shift_q <= byte_c;
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              ack_q     <= (ptr_q <= CHB_LAST_REG);
              wr_en_q   <= (ptr_q <= CHB_LAST_REG);
              wr_addr_q <= ptr_q[3:0];
              wr_data_q <= byte_c;
              state_q   <= CHB_ST_WDATA_ACK;
            end
          end
          CHB_ST_ADDR_ACK: begin
            cnt_q <= 3'h0;
            if (!ack_q) begin
              state_q <= CHB_ST_IDLE;
            end else if (rd_mode_q) begin
              tx_q    <= rd_data_c;
              state_q <= CHB_ST_RDATA;
            end else begin
              state_q <= CHB_ST_REG;
            end
          end
          CHB_ST_REG_ACK: begin
            cnt_q   <= 3'h0;
            state_q <= ack_q ? CHB_ST_WDATA : CHB_ST_IDLE;
          end
          CHB_ST_WDATA_ACK: begin
            cnt_q   <= 3'h0;
            ptr_q   <= (ptr_q == 8'hFF) ? ptr_q : ptr_q + 8'h01;
            state_q <= ack_q ? CHB_ST_WDATA : CHB_ST_IDLE;
          end
          CHB_ST_RDATA: begin
            tx_q  <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              ptr_q   <= (ptr_q == 8'hFF) ? ptr_q : ptr_q + 8'h01;
              state_q <= CHB_ST_RDATA_ACK;
            end
          end
          CHB_ST_RDATA_ACK: begin
            cnt_q <= 3'h0;
            if (!sda_f) begin
              tx_q    <= rd_data_c;
              state_q <= CHB_ST_RDATA;
            end else begin
              state_q <= CHB_ST_IDLE;
            end
          end
          default: begin
            state_q <= CHB_ST_IDLE;
          end
        endcase
      end
    end
  end

  // data line drive, changed at clock-line falls; start and stop release it with the clock line high
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sda_oe_out <= 1'b0;
    end else if (start_c || stop_c) begin
      sda_oe_out <= 1'b0;
    end else if (fall) begin
      unique case (state_q)
        CHB_ST_ADDR_ACK:  sda_oe_out <= ack_q;
        CHB_ST_REG_ACK:   sda_oe_out <= ack_q;
        CHB_ST_WDATA_ACK: sda_oe_out <= ack_q;
        CHB_ST_RDATA:     sda_oe_out <= !tx_q[7];
        default:          sda_oe_out <= 1'b0;
      endcase
    end
  end

  // open-drain: only ever drives low
  always_ff @(posedge mclk_in) begin
    sda_out <= 1'b0;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      bus_busy_out <= 1'b0;
    end else if (start_c) begin
      bus_busy_out <= 1'b1;
    end else if (stop_c) begin
      bus_busy_out <= 1'b0;
    end
  end

  // configuration fields towards the charger core
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      high_impedance_enable_out    <= CHB_RST_R00[CHB_HIZ_BIT];
      thermistor_bypass_out        <= CHB_RST_R00[CHB_BYPASS_BIT];
      remote_sense_disable_out     <= CHB_RST_R00[CHB_RSENSE_BIT];
      regulate_remote_sense_out    <= !CHB_RST_R00[CHB_RSENSE_BIT];
      input_current_limit_code_out <= CHB_RST_R00[CHB_ICL_MSB:0];
      charge_thermistor_good_out   <= 1'b0;
    end else begin
      high_impedance_enable_out    <= input_current_limit[CHB_HIZ_BIT];
      thermistor_bypass_out        <= input_current_limit[CHB_BYPASS_BIT];
      remote_sense_disable_out     <= input_current_limit[CHB_RSENSE_BIT];
      regulate_remote_sense_out    <= !input_current_limit[CHB_RSENSE_BIT];
      input_current_limit_code_out <= input_current_limit[CHB_ICL_MSB:0];
      charge_thermistor_good_out   <= input_current_limit[CHB_BYPASS_BIT] || thermistor_ok_in;
    end
  end

  // read/write control registers 01h-07h then 0Ch, lowest offset in low byte
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      control_bank_out <= {CHB_RST_RXX, CHB_RST_RXX, CHB_RST_RXX, CHB_RST_RXX,
                           CHB_RST_RXX, CHB_RST_R03, CHB_RST_R02, CHB_RST_R01};
    end else begin
      control_bank_out <= {bank[CHB_OFS_CHARGER_CONTROL_4],
                           bank[CHB_OFS_CHARGER_CONTROL_3],
                           bank[CHB_OFS_CHARGER_CONTROL_2],
                           bank[CHB_OFS_CHARGER_CONTROL_1],
                           bank[CHB_OFS_BATTERY_VOLTAGE_LIMIT],
                           bank[CHB_OFS_PRECHARGE_TERM_LIMIT],
                           bank[CHB_OFS_CHARGE_CURRENT_LIMIT],
                           bank[CHB_OFS_CHARGER_CONTROL_0]};
    end
  end

endmodule

// ==== dv/chb_top_sva.sv ====
// port-level assertion checker for the charger register bank
`timescale 1ns/1ns
module chb_top_sva
  import chb_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // bus and events
  input  wire logic       scl_in,
  input  wire logic       sda_oe_out,
  input  wire logic       src_select_in,
  input  wire logic       src_detect_done_in,
  input  wire logic       reg_reset_in,
  input  wire logic       watchdog_expired_in,
  input  wire logic       bus_busy_out,
  // configuration outputs
  input  wire logic       sense_detect_start_out,
  input  wire logic       charge_thermistor_good_out,
  input  wire logic       high_impedance_enable_out,
  input  wire logic       thermistor_bypass_out,
  input  wire logic       remote_sense_disable_out,
  input  wire logic       regulate_remote_sense_out,
  input  wire logic [4:0] input_current_limit_code_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  a_reset_fields: assert property (disable iff (1'b0) rst_in [*3] |->
    input_current_limit_code_out == CHB_ICL_CODE_2400MA && !high_impedance_enable_out)
    else $error("reset field values wrong");
  a_wdog_hiz_clear: assert property (watchdog_expired_in |-> ##2
    !high_impedance_enable_out)
    else $error("watchdog left high impedance set");
  a_wdog_keep_low: assert property (watchdog_expired_in && !bus_busy_out
    && !src_detect_done_in && !reg_reset_in |-> ##2
    input_current_limit_code_out == $past(input_current_limit_code_out)
    && thermistor_bypass_out == $past(thermistor_bypass_out))
    else $error("watchdog disturbed low fields");
  a_src_high_code: assert property (src_detect_done_in && src_select_in
    && $past(src_select_in, 6) && !reg_reset_in |-> ##2
    input_current_limit_code_out == CHB_ICL_CODE_500MA)
    else $error("select high did not load 500 mA");
  a_src_low_code: assert property (src_detect_done_in && !src_select_in
    && !$past(src_select_in, 6) && !reg_reset_in |-> ##2
    input_current_limit_code_out == CHB_ICL_CODE_2400MA)
    else $error("select low did not load 2.4 A");
  a_reg_reset_low: assert property (reg_reset_in |-> ##2 !thermistor_bypass_out
    && !remote_sense_disable_out && input_current_limit_code_out == CHB_ICL_CODE_2400MA)
    else $error("register reset left fields");
  a_sense_regulate: assert property (
    regulate_remote_sense_out != remote_sense_disable_out)
    else $error("regulation path not inverse of sense disable");
  a_bypass_good: assert property (thermistor_bypass_out |-> charge_thermistor_good_out)
    else $error("bypass did not force thermistor good");
  a_idle_no_drive: assert property (!bus_busy_out && !$past(bus_busy_out) |->
    !sda_oe_out)
    else $error("data driven while bus idle");
  a_drive_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_code_cause: assert property ($changed(input_current_limit_code_out) |->
    $past(bus_busy_out, 2) || $past(src_detect_done_in, 2) || $past(reg_reset_in, 2)
    || $past(rst_in, 2) || $past(rst_in))
    else $error("limit code changed without cause");

  c_watchdog: cover property (watchdog_expired_in);
  c_sense_start: cover property (sense_detect_start_out);
  c_ack_drive: cover property ($rose(sda_oe_out));
endmodule

// ==== dv/chb_host_model.sv ====
// bus master model standing in for the host controller
`timescale 1ns/1ns
module chb_host_model (
  // clock
  input  wire logic mclk_in,
  // bus wires
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  // data set mid-low, held through high, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    tk(5);
    sda_oe_out = !b;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    r = sda_in;
    tk(5);
    scl_out = 1'b0;
  endtask

  // also serves as repeated start
  task automatic start_c;
    tk(5);
    sda_oe_out = 1'b0;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    sda_oe_out = 1'b1;
    tk(5);
    scl_out = 1'b0;
  endtask

  task automatic stop_c;
    tk(5);
    sda_oe_out = 1'b1;
    tk(5);
    scl_out = 1'b1;
    tk(5);
    sda_oe_out = 1'b0;
    tk(10);
  endtask

  // msb first, then ninth bit; b = FF releases the line for reads
  task automatic xfer(input logic [7:0] b, input logic ackb, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(ackb, ack);
  endtask
endmodule

// ==== dv/chb_top_tb_top.sv ====
// self-checking testbench for the charger register bank
`timescale 1ns/1ns
module chb_top_tb_top
  import chb_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        sel = 1'b0, det = 1'b0, sdone = 1'b0, sabs = 1'b0, rrst = 1'b0, wdog = 1'b0;
  logic        tok = 1'b0;
  logic [7:0]  st [4] = '{8'hA5, 8'h3C, 8'h5A, 8'hC3};
  logic [7:0]  em [14] = '{8'h17, 8'h1A, 8'h91, 8'h12, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'hA5, 8'h3C, 8'h5A, 8'hC3, 8'h00, 8'hFF};
  logic [7:0]  rq [16];
  logic [15:0] nak;
  wire         scl_w, host_oe, sda_out, sda_oe_out, sense_detect_start_out, good, hiz;
  wire         bypass, rsdis, regulate, busy;
  wire  [4:0]  code;
  wire  [63:0] control_bank_out;
  wire         sda_w = ((sda_oe_out && !sda_out) || host_oe) ? 1'b0 : 1'b1;
  int          num_errors = 0, comparisons = 0, n_sense = 0, s0;

  always #4 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (sense_detect_start_out === 1'b1) n_sense <= n_sense + 1;

  chb_host_model host (.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl_w),
    .sda_oe_out(host_oe));

  chb_top uut (.mclk_in(mclk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .src_select_in(sel),
    .src_detect_done_in(det), .sense_done_in(sdone), .sense_absent_in(sabs),
    .sense_detect_start_out(sense_detect_start_out), .reg_reset_in(rrst),
    .watchdog_expired_in(wdog), .thermistor_ok_in(tok),
    .thermistor_fault_field_in(st[1][2:0]), .charge_thermistor_good_out(good),
    .status_0_in(st[0]), .status_1_in(st[1]), .status_2_in(st[2]), .part_info_in(st[3]),
    .high_impedance_enable_out(hiz), .thermistor_bypass_out(bypass),
    .remote_sense_disable_out(rsdis), .regulate_remote_sense_out(regulate),
    .input_current_limit_code_out(code), .control_bank_out(control_bank_out),
    .bus_busy_out(busy));

  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic pls(ref logic s);
    @(negedge mclk_in);
    s = 1'b1;
    @(negedge mclk_in);
    s = 1'b0;
    host.tk(8);
  endtask

  // register byte then n data bytes of d, d+11h, ...; stops at first refusal
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                    input int n);
    logic [7:0] r;
    logic       a;
    nak = 16'h0000;
    host.start_c();
    host.xfer({dev, 1'b0}, 1'b1, r, a);
    nak[0] = a;
    for (int i = 0; i <= n && nak == 16'h0000; i++) begin
      host.xfer((i == 0) ? ra : d + 8'(17 * (i - 1)), 1'b1, r, a);
      nak[i + 1] = a;
    end
    host.stop_c();
  endtask

  task automatic rd(input logic [7:0] ra, input int n);
    logic [7:0] r;
    logic       a;
    host.start_c();
    host.xfer({CHB_SLAVE_ADDR, 1'b0}, 1'b1, r, a);
    host.xfer(ra, 1'b1, r, a);
    host.start_c();
    host.xfer({CHB_SLAVE_ADDR, 1'b1}, 1'b1, r, a);
    for (int i = 0; i < n; i++) begin
      host.xfer(8'hFF, 1'(i == n - 1), r, a);
      rq[i] = r;
    end
    host.stop_c();
  endtask

  initial begin
    repeat (40000) @(posedge mclk_in);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (12) @(negedge mclk_in);
    rst_in = 1'b0;
    host.tk(8);
    chk_val({hiz, bypass, rsdis, regulate, good, code}, {5'b00010, 5'h17});
    chk_val(control_bank_out, 64'h0000_0000_0012_911A);
    rd(8'h00, 14);
    for (int i = 0; i < 14; i++) chk_val(rq[i], em[i]);
    wr(CHB_SLAVE_ADDR, 8'h00, 8'hE5, 1);
    chk_val(nak, 16'h0000);
    chk_val({hiz, bypass, rsdis, regulate, good, code}, 10'h3A5);
    rd(8'h09, 1);
    chk_val(rq[0], 8'h38);
    pls(wdog);
    rd(8'h00, 1);
    chk_val(rq[0], 8'h65);
    s0 = n_sense;
    wr(CHB_SLAVE_ADDR, 8'h00, 8'h45, 1);
    chk_val(n_sense - s0, 1);
    sabs = 1'b1;
    pls(sdone);
    rd(8'h00, 1);
    chk_val(rq[0], 8'h65);
    sel = 1'b1;
    host.tk(10);
    pls(det);
    rd(8'h00, 1);
    chk_val(rq[0], 8'h64);
    sel = 1'b0;
    host.tk(10);
    pls(det);
    rd(8'h00, 1);
    chk_val(rq[0], 8'h77);
    wr(CHB_SLAVE_ADDR, 8'h00, 8'h6A, 1);
    chk_val(code, 5'h0A);
    wr(CHB_SLAVE_ADDR, 8'h0B, 8'h11, 3);
    chk_val(nak, 16'h0010);
    rd(8'h0B, 2);
    chk_val({rq[0], rq[1], control_bank_out[63:56]}, 24'hC32222);
    wr(CHB_SLAVE_ADDR, 8'h0D, 8'h00, 1);
    chk_val(nak, 16'h0002);
    wr(CHB_SLAVE_ADDR + 7'h01, 8'h00, 8'h00, 1);
    chk_val(nak, 16'h0001);
    pls(rrst);
    rd(8'h00, 1);
    chk_val(rq[0], 8'h17);
    chk_val(control_bank_out, 64'h0000_0000_0012_911A);
    tok = 1'b1;
    host.tk(4);
    chk_val({bypass, good}, 2'h1);
    end_of_test();
  end
endmodule

bind chb_top chb_top_sva chk (.mclk_in, .rst_in, .scl_in, .sda_oe_out, .src_select_in,
  .src_detect_done_in, .reg_reset_in, .watchdog_expired_in, .bus_busy_out,
  .sense_detect_start_out, .charge_thermistor_good_out, .high_impedance_enable_out,
  .thermistor_bypass_out, .remote_sense_disable_out, .regulate_remote_sense_out,
  .input_current_limit_code_out);
